/* lcdcd_pkg.sv */
/*
 * Shared constants and types for the LCD driver command decoder:
 * register offsets, opcodes, field positions, reset values and the
 * packed structs for the drive state and the ram write port.
 * Assumes a 32-bit Avalon-MM slave with byte addresses.
 */
package lcdcd_pkg;

	// ==========================================================
	// bus map
	localparam logic [3:0] LCDCD_OFF_CMD = 4'h0;
	localparam logic [3:0] LCDCD_OFF_DATA = 4'h4;
	localparam logic [3:0] LCDCD_OFF_MODE = 4'h8;

	// ==========================================================
	// display geometry
	localparam int LCDCD_PAGES = 4;
	localparam int LCDCD_COLS = 80;
	localparam int LCDCD_RAM_WORDS = LCDCD_PAGES * LCDCD_COLS;
	localparam logic [6:0] LCDCD_COL_LAST = 7'h4F;
	localparam logic [6:0] LCDCD_COL_STOP = 7'h50;
	localparam logic [8:0] LCDCD_COLS_W = 9'h050;

	// ==========================================================
	// opcodes, matched with their option bits masked off
	localparam logic [7:0] LCDCD_OP_DISP = 8'hAE;
	localparam logic [7:0] LCDCD_MSK_DISP = 8'hFE;
	localparam logic [7:0] LCDCD_OP_START = 8'hC0;
	localparam logic [7:0] LCDCD_MSK_START = 8'hE0;
	localparam logic [7:0] LCDCD_OP_PAGE = 8'hB8;
	localparam logic [7:0] LCDCD_MSK_PAGE = 8'hFC;
	localparam logic [7:0] LCDCD_OP_COL = 8'h00;
	localparam logic [7:0] LCDCD_MSK_COL = 8'h80;
	localparam logic [7:0] LCDCD_OP_ADC = 8'hA0;
	localparam logic [7:0] LCDCD_OP_STATIC = 8'hA4;
	localparam logic [7:0] LCDCD_OP_DUTY = 8'hA8;
	localparam logic [7:0] LCDCD_MSK_OPT = 8'hFE;
	localparam logic [7:0] LCDCD_OP_RMW = 8'hE0;
	localparam logic [7:0] LCDCD_OP_END = 8'hEE;
	localparam logic [7:0] LCDCD_OP_RESET = 8'hE2;

	// ==========================================================
	// status byte bit positions
	localparam int LCDCD_ST_BUSY = 7;
	localparam int LCDCD_ST_ADC = 6;
	localparam int LCDCD_ST_OFF = 5;
	localparam int LCDCD_ST_RESET = 4;

	// ==========================================================
	// mode register field positions
	localparam int LCDCD_MD_COL = 0;
	localparam int LCDCD_MD_PAGE = 8;
	localparam int LCDCD_MD_START = 16;
	localparam int LCDCD_MD_RMW = 24;
	localparam int LCDCD_MD_STATIC = 25;
	localparam int LCDCD_MD_DUTY = 26;
	localparam int LCDCD_MD_PSAVE = 27;
	localparam int LCDCD_MD_DISP = 28;

	// ==========================================================
	// reset values
	localparam logic LCDCD_RST_DISP_ON = 1'b0;
	localparam logic LCDCD_RST_ADC_REV = 1'b0;
	localparam logic LCDCD_RST_STATIC = 1'b0;
	localparam logic LCDCD_RST_DUTY32 = 1'b0;

	// ==========================================================
	// drive state toward the lcd output stage
	typedef struct packed {
		logic drive_en;
		logic segcom_high;
		logic all_dots_on;
		logic com_all_select;
		logic duty32;
		logic adc_reverse;
		logic power_save;
		logic osc_enable;
		logic oscillator_output_pin_oe;
	} lcdcd_drive_t;

	localparam lcdcd_drive_t LCDCD_DRIVE_RST = '0;

	// ram write port
	typedef struct packed {
		logic we;
		logic [8:0] addr;
		logic [7:0] data;
	} lcdcd_ram_wr_t;

endpackage : lcdcd_pkg

/* lcdcd_dram.sv */
/*
 * Display data RAM: four pages of eighty byte columns.
 * One synchronous write port, one combinational read port.
 * Assumes the caller never writes an address past the last word.
 */
`timescale 1ns/1ps

module lcdcd_dram
	import lcdcd_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// write port
	input wire lcdcd_pkg::lcdcd_ram_wr_t wr,
	// read port
	input wire logic [8:0] rd_addr,
	output logic [7:0] rd_data
);
	// ==========================================================
	// storage; no reset, contents survive every reset
	logic [7:0] mem [LCDCD_RAM_WORDS];

	always_ff @(posedge ref_clk)
	begin
		if (wr.we)
		begin
			mem[wr.addr] <= wr.data;
		end
	end

	assign rd_data = mem[rd_addr];

endmodule : lcdcd_dram

/* lcdcd_top.sv */
/*
 * Command decoder for a dot-matrix LCD driver, reached by software
 * over an Avalon-MM slave with waitrequest. Command bytes go to the
 * command word, display bytes to the data word; a mode word reads
 * back the internal state. Drive state goes out as one struct.
 * Assumes the reset pin is asynchronous to ref_clk.
 */
// Design decisions made here: register access over Avalon-MM and the register addresses.
// Summary of operation
// - data write stores the byte at page and column, then steps column
// - data read returns the latched byte, reloads it from page and column, then steps column
// - segment order option: low forward, high reversed column order
// - column advance follows the chosen segment order
// - static drive on lights every dot, selects all commons
// - duty option: clear gives 1/16, set gives 1/32
// - in read-modify-write only writes advance the column
// - read-modify-write stays until the end command or a pin reset
// - end command leaves the mode and restores the saved column
// - soft reset clears start line, column and page, keeps ram
// - static drive on with display off enters power saving
// - power saving stops driving, outputs high, oscillator off
// - power saving keeps ram and every mode setting
// - display on or static off ends power saving
// - column advance stops at 80, no wrap, page untouched
// - display option bit: clear switches off, set switches on
// - busy reads high during reset; commands ignored meanwhile
`timescale 1ns/1ps

module lcdcd_top
	import lcdcd_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// reset pin, active low, asynchronous
	input wire logic external_reset_pin_n,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// drive state
	output lcdcd_pkg::lcdcd_drive_t drive,
	output logic [4:0] start_line
);
	import lcdcd_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		logic pin_meta;
		logic pin_sync;
		logic waitreq;
		logic [31:0] rdata;
		logic [6:0] col;
		logic [6:0] col_save;
		logic [1:0] page;
		logic [4:0] start;
		logic [7:0] latch;
		logic disp_on;
		logic adc_rev;
		logic static_on;
		logic duty32;
		logic rmw;
		logic soft_rst;
		lcdcd_drive_t drv;
	} lcdcd_state_t;

	lcdcd_state_t s_r;
	lcdcd_state_t s_nxt;
	lcdcd_ram_wr_t ram_wr;
	logic [8:0] ram_addr;
	logic [7:0] ram_q;

	// ==========================================================
	// ram address from page and ordered column
	function automatic logic [8:0] lcdcd_addr(input logic [1:0] pg,
		input logic [6:0] c, input logic rev);
		logic [6:0] phys;
		phys = rev ? 7'(LCDCD_COL_LAST - c) : c;
		lcdcd_addr = 9'(9'(pg) * LCDCD_COLS_W + 9'(phys));
	endfunction : lcdcd_addr

	// saturating column step
	function automatic logic [6:0] lcdcd_step(input logic [6:0] c);
		lcdcd_step = (c >= LCDCD_COL_STOP) ? c : 7'(c + 7'h01);
	endfunction : lcdcd_step

	assign ram_addr = lcdcd_addr(s_r.page, s_r.col, s_r.adc_rev);

	lcdcd_dram u_dram (
		.ref_clk(ref_clk),
		.wr(ram_wr),
		.rd_addr(ram_addr),
		.rd_data(ram_q)
	);

	// ==========================================================
	// next state
	logic busy;
	logic take;
	logic cmd_wr;
	logic dat_wr;
	logic dat_rd;
	logic [7:0] cb;
	logic col_ok;

	always_comb
	begin
		s_nxt = s_r;
		ram_wr = '0;
		// the first stage feeds only the second
		s_nxt.pin_meta = external_reset_pin_n;
		s_nxt.pin_sync = s_r.pin_meta;
		busy = !s_r.pin_sync || s_r.soft_rst;
		s_nxt.soft_rst = 1'b0;
		cb = avs_writedata[7:0];
		col_ok = s_r.col < LCDCD_COL_STOP;

		// one wait cycle, answer registered, effect at release
		// waitrequest is its own flop so the pin comes straight off it
		take = (avs_read || avs_write) && !s_r.waitreq;
		s_nxt.waitreq = 1'b1;
		if ((avs_read || avs_write) && s_r.waitreq)
		begin
			s_nxt.waitreq = 1'b0;
		end
		cmd_wr = take && avs_write && avs_byteenable[0] && !busy &&
			avs_address == LCDCD_OFF_CMD;
		dat_wr = take && avs_write && avs_byteenable[0] && !busy &&
			avs_address == LCDCD_OFF_DATA;
		dat_rd = take && avs_read && !busy &&
			avs_address == LCDCD_OFF_DATA;

		// read answer, captured while waitrequest is high
		if ((avs_read || avs_write) && s_r.waitreq)
		begin
			s_nxt.rdata = '0;
			if (avs_read)
			begin
				case (avs_address)
					LCDCD_OFF_CMD:
					begin
						s_nxt.rdata[LCDCD_ST_BUSY] = busy;
						s_nxt.rdata[LCDCD_ST_ADC] = !s_r.adc_rev;
						s_nxt.rdata[LCDCD_ST_OFF] = !s_r.disp_on;
						s_nxt.rdata[LCDCD_ST_RESET] = busy;
					end
					LCDCD_OFF_DATA:
					begin
						// latched byte: stale after a column load
						s_nxt.rdata[7:0] = s_r.latch;
					end
					LCDCD_OFF_MODE:
					begin
						s_nxt.rdata[LCDCD_MD_COL +: 7] = s_r.col;
						s_nxt.rdata[LCDCD_MD_PAGE +: 2] = s_r.page;
						s_nxt.rdata[LCDCD_MD_START +: 5] = s_r.start;
						s_nxt.rdata[LCDCD_MD_RMW] = s_r.rmw;
						s_nxt.rdata[LCDCD_MD_STATIC] = s_r.static_on;
						s_nxt.rdata[LCDCD_MD_DUTY] = s_r.duty32;
						s_nxt.rdata[LCDCD_MD_PSAVE] = s_r.drv.power_save;
						s_nxt.rdata[LCDCD_MD_DISP] = s_r.disp_on;
					end
					default:
					begin
						s_nxt.rdata = '0;
					end
				endcase
			end
		end

		// display data write
		if (dat_wr)
		begin
			ram_wr.we = col_ok;
			ram_wr.addr = ram_addr;
			ram_wr.data = cb;
			s_nxt.col = lcdcd_step(s_r.col);
		end

		// display data read: refill latch from the current column
		if (dat_rd)
		begin
			s_nxt.latch = col_ok ? ram_q : 8'h00;
			if (!s_r.rmw)
			begin
				s_nxt.col = lcdcd_step(s_r.col);
			end
		end

		// commands; unmatched bytes fall through untouched
		if (cmd_wr)
		begin
			if ((cb & LCDCD_MSK_DISP) == LCDCD_OP_DISP)
			begin
				s_nxt.disp_on = cb[0];
			end
			else if ((cb & LCDCD_MSK_START) == LCDCD_OP_START)
			begin
				s_nxt.start = cb[4:0];
			end
			else if ((cb & LCDCD_MSK_PAGE) == LCDCD_OP_PAGE)
			begin
				s_nxt.page = cb[1:0];
			end
			else if ((cb & LCDCD_MSK_COL) == LCDCD_OP_COL)
			begin
				s_nxt.col = cb[6:0];
			end
			else if ((cb & LCDCD_MSK_OPT) == LCDCD_OP_ADC)
			begin
				s_nxt.adc_rev = cb[0];
			end
			else if ((cb & LCDCD_MSK_OPT) == LCDCD_OP_STATIC)
			begin
				s_nxt.static_on = cb[0];
			end
			else if ((cb & LCDCD_MSK_OPT) == LCDCD_OP_DUTY)
			begin
				s_nxt.duty32 = cb[0];
			end
			else if (cb == LCDCD_OP_RMW)
			begin
				// re-entry keeps the first saved column
				if (!s_r.rmw)
				begin
					s_nxt.col_save = s_r.col;
				end
				s_nxt.rmw = 1'b1;
			end
			else if (cb == LCDCD_OP_END)
			begin
				if (s_r.rmw)
				begin
					s_nxt.col = s_r.col_save;
				end
				s_nxt.rmw = 1'b0;
			end
			else if (cb == LCDCD_OP_RESET)
			begin
				// ram untouched; mode bits kept
				s_nxt.start = '0;
				s_nxt.col = '0;
				s_nxt.page = '0;
				s_nxt.soft_rst = 1'b1;
			end
		end

		// reset pin held low: counters and modes to defaults, ram kept
		if (!s_r.pin_sync)
		begin
			s_nxt.col = '0;
			s_nxt.col_save = '0;
			s_nxt.page = '0;
			s_nxt.start = '0;
			s_nxt.latch = '0;
			s_nxt.disp_on = LCDCD_RST_DISP_ON;
			s_nxt.adc_rev = LCDCD_RST_ADC_REV;
			s_nxt.static_on = LCDCD_RST_STATIC;
			s_nxt.duty32 = LCDCD_RST_DUTY32;
			s_nxt.rmw = 1'b0;
		end

		// drive state from the settled settings
		s_nxt.drv.power_save = s_nxt.static_on && !s_nxt.disp_on;
		s_nxt.drv.drive_en = !s_nxt.drv.power_save;
		s_nxt.drv.segcom_high = s_nxt.drv.power_save;
		s_nxt.drv.osc_enable = !s_nxt.drv.power_save;
		// low enable leaves the oscillator pin floating
		s_nxt.drv.oscillator_output_pin_oe = !s_nxt.drv.power_save;
		s_nxt.drv.all_dots_on = s_nxt.static_on;
		s_nxt.drv.com_all_select = s_nxt.static_on;
		s_nxt.drv.duty32 = s_nxt.duty32;
		s_nxt.drv.adc_reverse = s_nxt.adc_rev;
	end

	// ==========================================================
	// registers
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			// pin stages start low: the block stays busy until the
			// pin has been seen high twice, so no early command slips in
			s_r <= '{pin_meta: 1'b0,
				pin_sync: 1'b0,
				waitreq: 1'b1,
				rdata: '0,
				col: '0,
				col_save: '0,
				page: '0,
				start: '0,
				latch: '0,
				disp_on: LCDCD_RST_DISP_ON,
				adc_rev: LCDCD_RST_ADC_REV,
				static_on: LCDCD_RST_STATIC,
				duty32: LCDCD_RST_DUTY32,
				rmw: 1'b0,
				soft_rst: 1'b0,
				drv: LCDCD_DRIVE_RST};
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign avs_readdata = s_r.rdata;
	assign avs_waitrequest = s_r.waitreq;
	assign drive = s_r.drv;
	assign start_line = s_r.start;

endmodule : lcdcd_top

/* lcdcd_checker.sv */
/*
 * Checker for lcdcd_top: bus handshake, command effects, power save.
 * Assumes only the top ports; bound to the top at the foot of this file.
 */
`timescale 1ns/1ps

module lcdcd_checker
	import lcdcd_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic external_reset_pin_n,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// drive state
	input wire lcdcd_pkg::lcdcd_drive_t drive,
	input wire logic [4:0] start_line
);
	// ==========================================================
	// command capture
	// commands are ignored while a pin reset drains, so wait it out
	logic [2:0] settle_r;
	logic take;
	logic [7:0] cb;
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || !external_reset_pin_n)
			settle_r <= 3'h0;
		else if (settle_r != 3'h7)
			settle_r <= settle_r + 3'h1;
	end
	assign cb = avs_writedata[7:0];
	assign take = avs_write && !avs_waitrequest && avs_byteenable[0]
		&& avs_address == LCDCD_OFF_CMD && settle_r > 3'h4;

	// ==========================================================
	// assertions
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_WAIT_ANSWER: assert property ((avs_read || avs_write) &&
		!$past(avs_read || avs_write) |=> !avs_waitrequest)
		else $error("no answer one cycle after request");
	AST_WAIT_CAUSE: assert property (!avs_waitrequest |->
		$past(avs_read || avs_write))
		else $error("answer without request");
	AST_PS_OUT: assert property (drive.power_save |->
		drive.segcom_high && !drive.drive_en)
		else $error("power save still driving");
	AST_PS_OSC: assert property (drive.power_save |->
		!drive.osc_enable && !drive.oscillator_output_pin_oe)
		else $error("oscillator alive in power save");
	AST_DUTY: assert property (take && (cb & LCDCD_MSK_OPT) == LCDCD_OP_DUTY
		|=> drive.duty32 == $past(cb[0]))
		else $error("duty not taken");
	AST_ADC: assert property (take && (cb & LCDCD_MSK_OPT) == LCDCD_OP_ADC
		|=> drive.adc_reverse == $past(cb[0]))
		else $error("segment order not taken");
	AST_PS_EXIT: assert property (take && (cb == 8'hAF || cb == 8'hA4)
		|=> !drive.power_save)
		else $error("power save not left");
	AST_SOFT_RST: assert property (take && cb == LCDCD_OP_RESET
		|=> start_line == 5'h00)
		else $error("start line not cleared");

	cover property (take && cb == LCDCD_OP_RMW);
	cover property (drive.power_save);
	cover property (avs_read && !avs_waitrequest);
endmodule : lcdcd_checker

bind lcdcd_top lcdcd_checker lcdcd_checker_inst (.ref_clk, .sys_rst,
	.external_reset_pin_n, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
	.drive, .start_line);

/* lcdcd_host.sv */
/*
 * Host model: an Avalon-MM master issuing one byte per transfer.
 * Assumes the slave answers with waitrequest low for one cycle.
 */
`timescale 1ns/1ps

module lcdcd_host (
	// clock
	input wire logic ref_clk,
	// master side
	output logic [3:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	initial
	begin
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'h0;
	end

	// ==========================================================
	// one transfer; an idle edge first so strobes never toggle twice
	task automatic xfer(input logic rd, input logic [3:0] a,
		input logic [7:0] d, input logic be, output logic [7:0] q);
		@(posedge ref_clk);
		avs_address <= a;
		avs_read <= rd;
		avs_write <= !rd;
		avs_writedata <= {24'h00_0000, d};
		avs_byteenable <= {3'h0, be};
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// released data lines must not look valid
		avs_writedata <= ~avs_writedata;
	endtask : xfer
endmodule : lcdcd_host

/* test_lcd_driver_command_decoder.sv */
/*
 * Self-checking bench for lcdcd_top, driven through the host model.
 * Assumes the package map; read results are checked from a queue.
 */
`timescale 1ns/1ps

module test_lcd_driver_command_decoder;
	import lcdcd_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic external_reset_pin_n = 1'b1;
	logic [3:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	lcdcd_drive_t drive;
	logic [4:0] start_line;
	int err_count = 0;
	int checks = 0;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [7:0] x [4];
	logic [7:0] q;

	always #12.5 ref_clk = ~ref_clk;

	lcdcd_top lcdcd_top_inst (.ref_clk, .sys_rst, .external_reset_pin_n,
		.avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .drive,
		.start_line);
	lcdcd_host lcdcd_host_inst (.ref_clk, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest);

	// ==========================================================
	// helpers
	task chk(string n, logic [31:0] s, logic [31:0] ev);
		checks++;
		if (s !== ev)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, ev, s);
		end
	endtask : chk

	task test_done();
		if (err_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	task cmd(logic [7:0] b);
		lcdcd_host_inst.xfer(1'b0, LCDCD_OFF_CMD, b, 1'b1, q);
	endtask : cmd

	task wr(logic [7:0] b);
		lcdcd_host_inst.xfer(1'b0, LCDCD_OFF_DATA, b, 1'b1, q);
	endtask : wr

	task rd(logic [3:0] a, logic [31:0] ev, logic [31:0] mv);
		exp_q.push_back(ev);
		msk_q.push_back(mv);
		lcdcd_host_inst.xfer(1'b1, a, 8'h00, 1'b1, q);
	endtask : rd

	always @(posedge ref_clk)
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
			chk("readdata", avs_readdata & msk_q.pop_front(), exp_q.pop_front());

	// ==========================================================
	// scenarios
	initial
	begin
		void'($urandom(26));
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		foreach (x[i]) x[i] = 8'($urandom());
		cmd(8'hB9);
		cmd(8'h4E);
		for (int i = 0; i < 3; i++) wr(x[i]);
		cmd(8'h4E);
		rd(LCDCD_OFF_DATA, 0, 0);
		rd(LCDCD_OFF_DATA, {24'h00_0000, x[0]}, 32'h0000_00FF);
		rd(LCDCD_OFF_DATA, {24'h00_0000, x[1]}, 32'h0000_00FF);
		rd(LCDCD_OFF_MODE, 32'h0000_0150, 32'h0000_03FF);
		// reversed order puts column 0 at the far end
		cmd(8'hA1);
		cmd(8'h00);
		wr(x[3]);
		cmd(8'hA0);
		cmd(8'h4F);
		rd(LCDCD_OFF_DATA, 0, 0);
		rd(LCDCD_OFF_DATA, {24'h00_0000, x[3]}, 32'h0000_00FF);
		cmd(8'h0A);
		wr(x[0]);
		wr(x[1]);
		cmd(8'h0A);
		rd(LCDCD_OFF_DATA, 0, 0);
		cmd(8'hE0);
		rd(LCDCD_OFF_DATA, {24'h00_0000, x[0]}, 32'h0000_00FF);
		rd(LCDCD_OFF_DATA, {24'h00_0000, x[1]}, 32'h0000_00FF);
		wr(x[2]);
		rd(LCDCD_OFF_MODE, 32'h0100_010C, 32'h0100_03FF);
		cmd(8'hEE);
		rd(LCDCD_OFF_MODE, 32'h0000_010B, 32'h0100_03FF);
		cmd(8'hC5);
		@(negedge ref_clk);
		chk("start_line", start_line, 32'h0000_0005);
		cmd(8'hE2);
		rd(LCDCD_OFF_MODE, 0, 32'h001F_03FF);
		cmd(8'hB9);
		cmd(8'h0A);
		rd(LCDCD_OFF_DATA, 0, 0);
		rd(LCDCD_OFF_DATA, {24'h00_0000, x[0]}, 32'h0000_00FF);
		for (int i = 0; i < 2; i++)
		begin
			cmd(8'hA8 | 8'(i));
			cmd(8'hAE);
			cmd(8'hA5);
			@(negedge ref_clk);
			chk("duty32", drive.duty32, 32'(i));
			chk("power_save", drive.power_save, 1);
			chk("segcom_high", drive.segcom_high, 1);
			chk("all_dots_on", drive.all_dots_on, 1);
			chk("com_all_select", drive.com_all_select, 1);
			rd(LCDCD_OFF_MODE, 32'h0A00_0000 | (i << 26), 32'h1F00_0000);
			cmd(i ? 8'hA4 : 8'hAF);
			@(negedge ref_clk);
			chk("power_save", drive.power_save, 0);
			chk("drive_en", drive.drive_en, 1);
			chk("all_dots_on", drive.all_dots_on, 32'(1 - i));
		end
		// unknown byte, masked and unmapped writes change nothing
		cmd(8'hE3);
		lcdcd_host_inst.xfer(1'b0, LCDCD_OFF_DATA, 8'h55, 1'b0, q);
		lcdcd_host_inst.xfer(1'b0, 4'hC, 8'hA5, 1'b1, q);
		rd(4'hC, 0, 32'hFFFF_FFFF);
		rd(LCDCD_OFF_MODE, 32'h0400_010C, 32'h1F1F_03FF);
		external_reset_pin_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rd(LCDCD_OFF_CMD, 32'h0000_00F0, 32'h0000_00F0);
		external_reset_pin_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rd(LCDCD_OFF_MODE, 0, 32'h1F1F_03FF);
		test_done();
	end

	initial
	begin
		repeat (5000) @(posedge ref_clk);
		err_count++;
		test_done();
	end
endmodule : test_lcd_driver_command_decoder
